// ==== logic/rt_cfg_pkg.sv ====
// Constants shared by the interrupt-mask and terminal-configuration block.
// Assumes a 50 MHz core clock and a 5-bit register address port.
package rt_cfg_pkg;
    // Register offsets
    localparam logic [4:0] OFFSET_MASK_ONE = 5'h00;
    localparam logic [4:0] OFFSET_CONFIG_ONE = 5'h01;
    // Mask register layout
    localparam logic [15:0] MASK_IMPLEMENTED = 16'h3cf7;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam int EVT_TX_TIMEOUT = 13;
    localparam int EVT_RT_STACK = 12;
    localparam int EVT_MON_CMD_STACK = 11;
    localparam int EVT_MON_DATA_STACK = 10;
    localparam int EVT_ADDR_PARITY = 7;
    localparam int EVT_TIME_TAG = 6;
    localparam int EVT_CIRC_BUFFER = 5;
    localparam int EVT_SELECTIVE_EOM = 4;
    localparam int EVT_MSG_ERROR = 2;
    localparam int EVT_MODE_CMD = 1;
    localparam int EVT_EOM = 0;
    // Configuration register layout
    localparam int CFG_ENHANCED_RT = 15;
    localparam int CFG_MONITOR_ONLY = 14;
    localparam int CFG_AREA_B = 13;
    localparam int CFG_MONITOR_ENABLE = 12;
    localparam int CFG_DYN_BUS = 11;
    localparam int CFG_BUSY_N = 10;
    localparam int CFG_SERVICE_REQ_N = 9;
    localparam int CFG_SUBSYS_FLAG_N = 8;
    localparam int CFG_TERM_FLAG_N = 7;
    localparam int CFG_MONITOR_RUNNING = 2;
    localparam int CFG_MSG_IN_PROGRESS = 0;
    localparam logic [15:0] CFG_WRITABLE = 16'hff80;
    localparam logic [15:0] CFG_ALT_WRITABLE = 16'hfffe;
    localparam logic [15:0] CFG_RESET_IDLE_BC = 16'h0000;
    localparam logic [15:0] CFG_RESET_BUSY_RT = 16'h8000;
    // Status word bit positions (low 11 bits)
    localparam int SW_TERM_FLAG = 0;
    localparam int SW_DYN_BUS_ACCEPT = 1;
    localparam int SW_SUBSYS_FLAG = 2;
    localparam int SW_BUSY = 3;
    localparam int SW_SERVICE_REQ = 8;
    localparam logic [15:0] TIME_TAG_MAX = 16'hffff;
    // Transmitter watchdog timing
    localparam int CLK_MHZ = 50;
    localparam int TX_TIMEOUT_US = 768;
    localparam int TX_TIMEOUT_CYCLES = TX_TIMEOUT_US * CLK_MHZ;
endpackage : rt_cfg_pkg

// ==== logic/event_latch.sv ====
// Sticky event flags with per-bit mask gating onto one interrupt level.
// Assumes set and clear inputs are one-cycle pulses from the core clock domain.
`timescale 1ns/1ps
module event_latch #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] setPulse,
    input wire logic [WIDTH-1:0] clearPulse,
    input wire logic [WIDTH-1:0] mask,
    output logic [WIDTH-1:0] flags,
    output logic irq
);
    wire logic [WIDTH-1:0] next_flags;
    wire logic next_irq;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            // Set wins over a clear in the same cycle
            assign next_flags[i] = setPulse[i] | (flags[i] & ~clearPulse[i]);
        end
    endgenerate

    assign next_irq = |(flags & mask);

    // Flag and interrupt registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= '0;
            irq <= 1'b0;
        end else begin
            flags <= next_flags;
            irq <= next_irq;
        end
    end

    a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
        irq == $past(|(flags & mask)))
        else $error("interrupt does not follow masked flags");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        |setPulse |=> ((flags & $past(setPulse)) == $past(setPulse)))
        else $error("event flag not recorded");
endmodule : event_latch

// ==== logic/tx_watchdog.sv ====
// Transmitter-on watchdog: one pulse when the transmitter stays on too long.
// Assumes txActive is a synchronous level from the encoder.
`timescale 1ns/1ps
module tx_watchdog #(
    parameter int LIMIT = 38400
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic txActive,
    output logic timeout
);
    localparam int CW = $clog2(LIMIT + 2);
    logic [CW-1:0] count;
    wire logic atLimit;
    wire logic [CW-1:0] next_count;

    assign atLimit = (count == CW'(LIMIT));
    assign next_count = !txActive ? '0 : (count > CW'(LIMIT)) ? count : count + 1'b1;

    // Counter saturates past the limit so the pulse fires once per burst
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
            timeout <= 1'b0;
        end else begin
            count <= next_count;
            timeout <= txActive && atLimit;
        end
    end

    a_timeout_once: assert property (@(posedge clk) disable iff (!rst_n)
        timeout |=> !timeout)
        else $error("timeout pulse longer than one cycle");
endmodule : tx_watchdog

// ==== logic/rt_irq_config_regs.sv ====
// Interrupt mask #1 and configuration #1 registers of the terminal engine.
// Assumes a synchronous register port from the host bus interface and
// one-cycle event pulses from the protocol engine, all on clk.
`timescale 1ns/1ps
module rt_irq_config_regs #(
    parameter int TX_LIMIT_CYCLES = rt_cfg_pkg::TX_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic compat_busy_powerup_input,
    input wire logic [4:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic regRdValid,
    input wire logic message_start,
    input wire logic message_finish,
    input wire logic subaddrIrqRequest,
    input wire logic modeCommandValid,
    input wire logic loopbackError,
    input wire logic statusMsgError,
    input wire logic circBufferWrap,
    input wire logic txActive,
    input wire logic timeTagTick,
    input wire logic [4:0] rtAddress,
    input wire logic rtAddressParity,
    input wire logic rtStackWrite,
    input wire logic [15:0] rtStackAddr,
    input wire logic [15:0] rtStackBase,
    input wire logic monCmdStackWrite,
    input wire logic [15:0] monCmdStackAddr,
    input wire logic [15:0] monCmdStackBase,
    input wire logic monDataStackWrite,
    input wire logic [15:0] monDataStackAddr,
    input wire logic [15:0] monDataStackBase,
    input wire logic bus_monitor_function,
    input wire logic altStatusSelect,
    input wire logic [15:0] statusClear,
    output logic [15:0] eventFlags,
    output logic hostIrq,
    output logic [15:0] timeTag,
    output logic enhancedRt,
    output logic monitorOnly,
    output logic monitorEnable,
    output logic areaB,
    output logic rtBusy,
    output logic [10:0] statusWordLow
);
    import rt_cfg_pkg::*;

    logic [15:0] intMask;
    logic [15:0] cfgWritable;
    logic msgInProgress;
    logic txTimeout;

    // Register decode
    wire logic selMask = (regAddr == OFFSET_MASK_ONE);
    wire logic selCfg = (regAddr == OFFSET_CONFIG_ONE);
    wire logic writeMask = regWrite && selMask;
    wire logic writeCfg = regWrite && selCfg;

    // Mask register: only implemented bits are stored
    // unused bits zero
    wire logic [15:0] next_intMask = writeMask ? (regWrData & MASK_IMPLEMENTED) : intMask;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intMask <= MASK_RESET;
        end else begin
            intMask <= next_intMask;
        end
    end

    // Configuration writable bits; reset value caught from the strap
    // strap picks reset mode
    wire logic [15:0] cfgResetValue = compat_busy_powerup_input ? CFG_RESET_BUSY_RT
                                                                : CFG_RESET_IDLE_BC;
    // alternate layout also keeps bits 6..1 for the status copy
    wire logic altWrite = altStatusSelect && regWrData[CFG_ENHANCED_RT];
    wire logic [15:0] cfgWriteMask = altWrite ? CFG_ALT_WRITABLE : CFG_WRITABLE;
    wire logic [15:0] next_cfgWritable = writeCfg ? (regWrData & cfgWriteMask) : cfgWritable;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfgWritable <= cfgResetValue;
        end else begin
            cfgWritable <= next_cfgWritable;
        end
    end

    // Message in progress: set on start, cleared on finish
    // start sets, finish clears
    wire logic next_msgInProgress = message_start | (msgInProgress & ~message_finish);

    // Area change waits for the message boundary
    // area switch deferred
    wire logic areaMayChange = !msgInProgress || message_finish;
    wire logic next_areaB = areaMayChange ? cfgWritable[CFG_AREA_B] : areaB;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            msgInProgress <= 1'b0;
            areaB <= 1'b0;
        end else begin
            msgInProgress <= next_msgInProgress;
            areaB <= next_areaB;
        end
    end

    // Time tag counter
    // wrap detection
    wire logic timeTagWrap = timeTagTick && (timeTag == TIME_TAG_MAX);
    wire logic [15:0] next_timeTag = timeTagTick ? timeTag + 16'h0001 : timeTag;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timeTag <= 16'h0000;
        end else begin
            timeTag <= next_timeTag;
        end
    end

    tx_watchdog #(
        .LIMIT(TX_LIMIT_CYCLES)
    ) u_watchdog (
        .clk(clk),
        .rst_n(rst_n),
        .txActive(txActive),
        .timeout(txTimeout)
    );

    // Event sources gathered onto mask bit positions
    // stack rollover compare
    wire logic rtStackRoll = rtStackWrite && (rtStackAddr == rtStackBase);
    wire logic monCmdRoll = monCmdStackWrite && (monCmdStackAddr == monCmdStackBase);
    wire logic monDataRoll = monDataStackWrite && (monDataStackAddr == monDataStackBase);
    // odd parity over address and parity bit
    wire logic parityError = ~(^{rtAddress, rtAddressParity});
    wire logic selectiveEom = message_finish && subaddrIrqRequest;
    wire logic msgError = loopbackError || statusMsgError;

    wire logic [15:0] eventPulse;
    assign eventPulse[15:14] = 2'b00;
    assign eventPulse[EVT_TX_TIMEOUT] = txTimeout;
    assign eventPulse[EVT_RT_STACK] = rtStackRoll;
    assign eventPulse[EVT_MON_CMD_STACK] = monCmdRoll;
    assign eventPulse[EVT_MON_DATA_STACK] = monDataRoll;
    assign eventPulse[9:8] = 2'b00;
    assign eventPulse[EVT_ADDR_PARITY] = parityError;
    assign eventPulse[EVT_TIME_TAG] = timeTagWrap;
    assign eventPulse[EVT_CIRC_BUFFER] = circBufferWrap;
    assign eventPulse[EVT_SELECTIVE_EOM] = selectiveEom;
    assign eventPulse[3] = 1'b0;
    assign eventPulse[EVT_MSG_ERROR] = msgError;
    assign eventPulse[EVT_MODE_CMD] = modeCommandValid;
    assign eventPulse[EVT_EOM] = message_finish;

    event_latch #(
        .WIDTH(16)
    ) u_events (
        .clk(clk),
        .rst_n(rst_n),
        .setPulse(eventPulse),
        .clearPulse(statusClear),
        .mask(intMask),
        .flags(eventFlags),
        .irq(hostIrq)
    );

    // Mode outputs
    // enhanced terminal select
    wire logic next_enhancedRt = cfgWritable[CFG_ENHANCED_RT];
    wire logic next_monitorOnly = cfgWritable[CFG_MONITOR_ONLY] && !cfgWritable[CFG_ENHANCED_RT];
    wire logic next_monitorEnable = cfgWritable[CFG_MONITOR_ENABLE];
    wire logic next_rtBusy = !cfgWritable[CFG_BUSY_N];

    // Status word low bits, normal flag form
    // active-low flag bits
    wire logic [10:0] normalStatus = {
        2'b00, !cfgWritable[CFG_SERVICE_REQ_N], 4'h0,
        !cfgWritable[CFG_BUSY_N], !cfgWritable[CFG_SUBSYS_FLAG_N],
        1'b0, !cfgWritable[CFG_TERM_FLAG_N]
    };
    wire logic useAltStatus = altStatusSelect && cfgWritable[CFG_ENHANCED_RT];
    wire logic [10:0] rawStatus = useAltStatus ? cfgWritable[11:1] : normalStatus;
    wire logic [10:0] next_statusWordLow = rawStatus & ~(11'h001 << SW_DYN_BUS_ACCEPT);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enhancedRt <= 1'b0;
            monitorOnly <= 1'b0;
            monitorEnable <= 1'b0;
            rtBusy <= 1'b0;
            statusWordLow <= 11'h000;
        end else begin
            enhancedRt <= next_enhancedRt;
            monitorOnly <= next_monitorOnly;
            monitorEnable <= next_monitorEnable;
            rtBusy <= next_rtBusy;
            statusWordLow <= next_statusWordLow;
        end
    end

    // Read image of the configuration register
    // monitor running bit
    wire logic [15:0] cfgNormalImage = {
        cfgWritable[15:14], areaB, cfgWritable[12:7], 4'h0,
        bus_monitor_function, 1'b0, msgInProgress
    };
    // alternate layout reads back the copied status bits
    wire logic [15:0] cfgAltImage = {
        cfgWritable[15:14], areaB, cfgWritable[12:1], msgInProgress
    };
    wire logic [15:0] cfgReadImage = useAltStatus ? cfgAltImage : cfgNormalImage;
    wire logic [15:0] readMux = selMask ? intMask : selCfg ? cfgReadImage : 16'h0000;

    // Read data registered one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdData <= regRead ? readMux : regRdData;
            regRdValid <= regRead;
        end
    end

    a_mask_unused: assert property (@(posedge clk) disable iff (!rst_n)
        (intMask & ~MASK_IMPLEMENTED) == 16'h0000)
        else $error("unimplemented mask bit stored");
    a_tag_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        (timeTagTick && timeTag == TIME_TAG_MAX) |=> eventFlags[EVT_TIME_TAG])
        else $error("time tag wrap not flagged");
    a_stack_roll: assert property (@(posedge clk) disable iff (!rst_n)
        rtStackRoll |=> eventFlags[EVT_RT_STACK])
        else $error("stack rollover not flagged");
    sequence s_midMessage;
        msgInProgress && !message_finish;
    endsequence
    a_area_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_midMessage |=> $stable(areaB))
        else $error("area changed inside a message");
    a_dbca_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !statusWordLow[SW_DYN_BUS_ACCEPT])
        else $error("dynamic bus acceptance set");
    a_busy_status: assert property (@(posedge clk) disable iff (!rst_n)
        (!useAltStatus && !cfgWritable[CFG_BUSY_N]) |=> statusWordLow[SW_BUSY] && rtBusy)
        else $error("busy not shown in status");
    sequence s_msgStart;
        message_start && !message_finish;
    endsequence
    a_msg_progress: assert property (@(posedge clk) disable iff (!rst_n)
        s_msgStart |=> msgInProgress)
        else $error("message in progress not set");
    a_flag_masked: assert property (@(posedge clk) disable iff (!rst_n)
        (intMask == 16'h0000) |=> ##1 !hostIrq || $past(intMask) != 16'h0000)
        else $error("interrupt with all events masked");
    a_parity_flag: assert property (@(posedge clk) disable iff (!rst_n)
        parityError |=> eventFlags[EVT_ADDR_PARITY])
        else $error("address parity error not flagged");
    a_mode_flag: assert property (@(posedge clk) disable iff (!rst_n)
        modeCommandValid |=> eventFlags[EVT_MODE_CMD])
        else $error("mode command not flagged");
    a_timeout_flag: assert property (@(posedge clk) disable iff (!rst_n)
        txTimeout |=> eventFlags[EVT_TX_TIMEOUT])
        else $error("transmitter timeout not flagged");
    a_svc_request: assert property (@(posedge clk) disable iff (!rst_n)
        (!useAltStatus && !cfgWritable[CFG_SERVICE_REQ_N]) |=> statusWordLow[SW_SERVICE_REQ])
        else $error("service request not shown in status");
    a_alt_copy: assert property (@(posedge clk) disable iff (!rst_n)
        useAltStatus |=> statusWordLow == ($past(cfgWritable[11:1]) & 11'h7fd))
        else $error("alternate status not copied");
    a_monitor_bit: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && selCfg && !useAltStatus) |=>
            regRdData[CFG_MONITOR_RUNNING] == $past(bus_monitor_function))
        else $error("monitor running bit wrong on read");
endmodule : rt_irq_config_regs

// ==== sim/host_model.sv ====
// Host processor model: single-word register writes and reads.
// Assumes the block's strobe-style register port on the rising clock edge.
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic [4:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid
);
    initial begin
        {regAddr, regWrite, regRead, regWrData} = '0;
    end
    // One-cycle write strobe; data is scrambled once released
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        // bit 14 low in terminal mode
        if (a == rt_cfg_pkg::OFFSET_CONFIG_ONE && v[15])
            v[14] = 1'b0;
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        regWrData <= ~v;
    endtask : wr
    // One-cycle read strobe, answer awaited for a few cycles
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = '0;
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            if (regRdValid === 1'b1) begin
                ok = 1'b1;
                d = regRdData;
            end
        end
    endtask : rd
endmodule : host_model

// ==== sim/tb_rt_irq_config_regs.sv ====
// Self-checking bench for the interrupt mask and configuration registers.
// Assumes host_model drives the register port; events are driven here.
`timescale 1ns/1ps
module tb_rt_irq_config_regs;
    import rt_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic compat_busy_powerup_input = 1'b1;
    logic [4:0] regAddr, rtAddress;
    logic regWrite, regRead, regRdValid, hostIrq, rtAddressParity;
    logic message_start, message_finish, subaddrIrqRequest, modeCommandValid;
    logic loopbackError, statusMsgError, circBufferWrap, txActive, timeTagTick;
    logic rtStackWrite, monCmdStackWrite, monDataStackWrite;
    logic bus_monitor_function, altStatusSelect;
    logic enhancedRt, monitorOnly, monitorEnable, areaB, rtBusy;
    logic [15:0] regWrData, regRdData, statusClear, eventFlags, timeTag;
    logic [15:0] rtStackAddr, rtStackBase, monCmdStackAddr, monCmdStackBase;
    logic [15:0] monDataStackAddr, monDataStackBase, m, v, e;
    logic [10:0] statusWordLow;
    int error_cnt = 0;
    int cmp_count = 0;
    // Event codes; 3 is status message error, 14 is no-event corners
    int codes[12] = '{0, 1, 2, 3, 4, 5, 7, 10, 11, 12, 13, 14};

    always #10 clk = ~clk;

    rt_irq_config_regs #(.TX_LIMIT_CYCLES(20)) u_dut (.clk, .rst_n, .compat_busy_powerup_input,
        .regAddr, .regWrite, .regRead, .regWrData, .regRdData, .regRdValid, .message_start,
        .message_finish, .subaddrIrqRequest, .modeCommandValid, .loopbackError,
        .statusMsgError, .circBufferWrap, .txActive, .timeTagTick, .rtAddress,
        .rtAddressParity, .rtStackWrite, .rtStackAddr, .rtStackBase, .monCmdStackWrite,
        .monCmdStackAddr, .monCmdStackBase, .monDataStackWrite, .monDataStackAddr,
        .monDataStackBase, .bus_monitor_function, .altStatusSelect, .statusClear,
        .eventFlags, .hostIrq, .timeTag, .enhancedRt, .monitorOnly, .monitorEnable,
        .areaB, .rtBusy, .statusWordLow);
    host_model u_host (.clk, .regAddr, .regWrite, .regRead, .regWrData, .regRdData,
        .regRdValid);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [4:0] a, input logic [15:0] x, input string s);
        logic [15:0] d;
        logic ok;
        u_host.rd(a, d, ok);
        if (!ok) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: no read answer", $time);
            results();
        end else
            chk(d, x, s);
    endtask : rdc
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    // Flags an event code is expected to leave behind
    function automatic logic [15:0] expf(input int k);
        case (k)
            3: expf = 16'h0004;
            4: expf = 16'h0011;
            14: expf = 16'h0000;
            default: expf = 16'h0001 << k;
        endcase
    endfunction : expf
    // Clear all flags, then raise one event source
    task automatic fire(input int k);
        @(posedge clk);
        statusClear <= 16'hffff;
        @(posedge clk);
        statusClear <= 16'h0000;
        case (k)
            0: message_finish <= 1'b1;
            1: modeCommandValid <= 1'b1;
            2: loopbackError <= 1'b1;
            3: statusMsgError <= 1'b1;
            4: {message_finish, subaddrIrqRequest} <= 2'b11;
            5: circBufferWrap <= 1'b1;
            7: rtAddressParity <= ^rtAddress;
            10: {monDataStackWrite, monDataStackAddr} <= {1'b1, monDataStackBase};
            11: {monCmdStackWrite, monCmdStackAddr} <= {1'b1, monCmdStackBase};
            12: {rtStackWrite, rtStackAddr} <= {1'b1, rtStackBase};
            // Off-base stack writes and transmitter on for 25 cycles (code 13) or exactly the limit of 20 (code 14)
            default: {txActive, rtStackWrite, monCmdStackWrite, monDataStackWrite} <= 4'hf;
        endcase
        repeat (k == 13 ? 25 : (k == 14 ? 20 : 1)) @(posedge clk);
        {message_finish, subaddrIrqRequest, modeCommandValid, loopbackError} <= '0;
        {statusMsgError, circBufferWrap, txActive, rtStackWrite} <= '0;
        {monCmdStackWrite, monDataStackWrite} <= '0;
        rtAddressParity <= ~^rtAddress;
        rtStackAddr <= rtStackBase + 16'h0001;
        monCmdStackAddr <= monCmdStackBase + 16'h0001;
        monDataStackAddr <= monDataStackBase + 16'h0001;
    endtask : fire

    initial begin
        void'($urandom(2));
        {message_start, message_finish, subaddrIrqRequest, modeCommandValid} = '0;
        {loopbackError, statusMsgError, circBufferWrap, txActive, timeTagTick} = '0;
        {rtStackWrite, monCmdStackWrite, monDataStackWrite} = '0;
        {bus_monitor_function, altStatusSelect, statusClear} = '0;
        rtAddress = 5'($urandom);
        rtAddressParity = ~^rtAddress;
        {rtStackBase, monCmdStackBase, monDataStackBase} = {16'($urandom), 32'($urandom)};
        rtStackAddr = rtStackBase + 16'h0001;
        monCmdStackAddr = monCmdStackBase + 16'h0001;
        monDataStackAddr = monDataStackBase + 16'h0001;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(OFFSET_CONFIG_ONE, CFG_RESET_BUSY_RT, "strap config");
        chk({15'h0, rtBusy}, 16'h0001, "strap busy");
        rdc(OFFSET_MASK_ONE, MASK_RESET, "mask reset");
        rdc(5'h1a, 16'h0000, "unmapped read");
        @(posedge clk);
        {compat_busy_powerup_input, rst_n} <= 2'b00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(OFFSET_CONFIG_ONE, CFG_RESET_IDLE_BC, "idle config");
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            m = (p == 0) ? 16'($urandom) : ~m;
            u_host.wr(OFFSET_MASK_ONE, m);
            rdc(OFFSET_MASK_ONE, m & MASK_IMPLEMENTED, "mask readback");
            foreach (codes[i]) begin
                fire(codes[i]);
                repeat (3) @(negedge clk);
                chk(eventFlags, expf(codes[i]), "event flags");
                chk({15'h0, hostIrq}, {15'h0, |(expf(codes[i]) & m)}, "irq");
            end
        end
        $display("test events done");
        @(posedge clk);
        timeTagTick <= 1'b1;
        repeat (65535) @(posedge clk);
        timeTagTick <= 1'b0;
        @(negedge clk);
        chk(timeTag, TIME_TAG_MAX, "tag at top");
        chk(eventFlags, 16'h0000, "no early wrap");
        @(posedge clk);
        timeTagTick <= 1'b1;
        @(posedge clk);
        timeTagTick <= 1'b0;
        repeat (3) @(negedge clk);
        chk(eventFlags, 16'h0040, "tag wrap");
        chk(timeTag, 16'h0000, "tag back to zero");
        $display("test time tag done");
        for (int i = 0; i < 6; i++) begin
            v = 16'($urandom) | 16'h8000;
            v[14] = 1'b0;
            v[3] = i[0];
            @(posedge clk);
            {bus_monitor_function, altStatusSelect} <= v[4:3];
            u_host.wr(OFFSET_CONFIG_ONE, v);
            e = v[3] ? (v & 16'hfffe) : ((v & CFG_WRITABLE) | {13'h0, v[4], 2'b00});
            rdc(OFFSET_CONFIG_ONE, e, "config readback");
            chk({13'h0, enhancedRt, monitorOnly, monitorEnable}, {13'h0, 2'b10, v[12]}, "modes");
            chk({15'h0, rtBusy}, {15'h0, ~v[10]}, "busy");
            chk({15'h0, statusWordLow[1]}, 16'h0000, "dynamic bus bit");
            if (v[3])
                chk({5'h0, statusWordLow}, {5'h0, v[11:1] & 11'h7fd}, "alt status");
            else
                chk({12'h0, statusWordLow[8], statusWordLow[3:2], statusWordLow[0]},
                    {12'h0, ~{v[9], v[10], v[8], v[7]}}, "status flags");
        end
        u_host.wr(OFFSET_CONFIG_ONE, 16'h4400);
        repeat (2) @(negedge clk);
        chk({14'h0, enhancedRt, monitorOnly}, 16'h0001, "legacy monitor");
        $display("test config done");
        @(posedge clk);
        {bus_monitor_function, altStatusSelect} <= 2'b00;
        u_host.wr(OFFSET_CONFIG_ONE, 16'h8400);
        @(posedge clk);
        message_start <= 1'b1;
        @(posedge clk);
        message_start <= 1'b0;
        u_host.wr(OFFSET_CONFIG_ONE, 16'ha400);
        rdc(OFFSET_CONFIG_ONE, 16'h8401, "area held mid message");
        @(posedge clk);
        message_finish <= 1'b1;
        @(posedge clk);
        message_finish <= 1'b0;
        repeat (2) @(negedge clk);
        chk({15'h0, areaB}, 16'h0001, "area after finish");
        rdc(OFFSET_CONFIG_ONE, 16'ha400, "message ended");
        $display("test area done");
        results();
    end
endmodule : tb_rt_irq_config_regs
